// ==== idc_consts.svh ====
// Offsets, field positions, reset values and cycle counts of the idle and doze controller.
// Included by the package and by every design file that needs a number.
`ifndef IDC_CONSTS_SVH
`define IDC_CONSTS_SVH

`define IDC_ADDR_W     8
`define IDC_OFS_CLOCK_DIVIDER_CONTROL 8'h00
`define IDC_OFS_CFG    8'h04
`define IDC_OFS_GATE   8'h08
`define IDC_OFS_STAT   8'h0C

`define IDC_BIT_ROI    15
`define IDC_RATIO_HI   14
`define IDC_RATIO_LO   12
`define IDC_BIT_SLOW   11
`define IDC_BIT_WDTEN  0
`define IDC_BIT_FMEN   1

`define IDC_RATIO_RST  3'h0
`define IDC_CFG_RST    1'h0
`define IDC_GATE_RST   16'h0000
`define IDC_MOD_MAX    16
`define IDC_DIV_W      7

// Cycles from the reapplied CPU clock to the resume pulse.
`define IDC_WAKE_CYC   2'h3

`endif

// ==== idc_cpu_model.sv ====
// Behavioural model of the CPU core and interrupt sources beside the power controller.
// Assumes the bench raises its requests just after a rising edge of pclk.
`timescale 1ns/1ns

module idc_cpu_model (
	input  logic pclk,
	input  logic presetn,
	input  logic req_idle,
	input  logic req_irq,
	input  logic req_wdt,
	input  logic cpu_clk_en,
	output logic psave_idle,
	output logic irq_pending,
	output logic wdt_timeout
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			psave_idle <= 1'h0;
			irq_pending <= 1'h0;
			wdt_timeout <= 1'h0;
		end else begin
			// A stopped CPU cannot execute another power save instruction.
			psave_idle <= req_idle & cpu_clk_en;
			irq_pending <= req_irq;
			wdt_timeout <= req_wdt;
		end
	end
endmodule

// ==== idc_doze_div.sv ====
// CPU clock enable divider for doze operation.
// Runs on the peripheral clock; the tick marks the CPU edges that are kept.
`timescale 1ns/1ns
`include "idc_consts.svh"

module idc_doze_div (
	input  logic       pclk,
	input  logic       presetn,
	input  logic       enable,
	input  logic [2:0] ratio,
	output logic       tick
);
	import idc_pkg::*;

	idc_div_state_t             st_ff;
	idc_div_state_t             nxt_st;
	logic [`IDC_DIV_W-1:0]      mask;

	// Counter counts on pclk while enabled and is held at zero otherwise, so every CPU edge lands on a peripheral edge.
	always_comb begin
		mask = ~({`IDC_DIV_W{1'b1}} << ratio);
		nxt_st = st_ff;
		nxt_st.cnt = enable ? ((st_ff.cnt + `IDC_DIV_W'(1)) & mask) : '0;
		nxt_st.tick = ~enable | (nxt_st.cnt == '0);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '{cnt: '0, tick: 1'b1};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign tick = st_ff.tick;

	AST_DIV_HALF: assert property (@(posedge pclk) disable iff (!presetn)
		(enable && $stable(enable) && ratio == 3'h1 && $stable(ratio) && tick) |=> !tick)
		else $error("doze ratio 1:2 did not skip a cycle");

endmodule

// ==== idc_mod_gate.sv ====
// Clock enable for one peripheral module, following its gate bit one cycle late.
// The gate bit comes from a register in the same clock domain.
`timescale 1ns/1ns

module idc_mod_gate (
	input  logic pclk,
	input  logic presetn,
	input  logic gate_off,
	output logic clk_en
);
	import idc_pkg::*;

	idc_gate_state_t st_ff;
	idc_gate_state_t nxt_st;

	always_comb begin
		nxt_st.en = ~gate_off;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '{en: 1'b1};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign clk_en = st_ff.en;

	AST_GATE_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(gate_off) |=> (clk_en == !$past(gate_off)) && $changed(clk_en))
		else $error("module clock enable did not follow its gate one cycle late");

endmodule

// ==== idc_pkg.sv ====
// Types shared by the idle and doze controller files.
// Assumes idc_consts.svh sits in the include path.
`include "idc_consts.svh"

package idc_pkg;

	typedef struct packed {
		logic                     psel;
		logic                     penable;
		logic                     pwrite;
		logic [`IDC_ADDR_W-1:0]   paddr;
		logic [31:0]              pwdata;
	} idc_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} idc_apb_rsp_t;

	typedef enum logic [1:0] {
		IDC_RUN   = 2'h0,
		IDC_ENTER = 2'h1,
		IDC_IDLE  = 2'h3,
		IDC_WAKE  = 2'h2
	} idc_pwr_t;

	typedef struct packed {
		idc_pwr_t                 pwr;
		logic [1:0]               wake_cnt;
		logic                     wake_pend;
		logic                     by_irq;
		logic                     by_wdt;
		logic                     return_on_interrupt;
		logic [2:0]               ratio;
		logic                     slow;
		logic                     wdt_en;
		logic                     fm_en;
		logic [`IDC_MOD_MAX-1:0]  gate;
		logic                     cpu_clk_en;
		logic                     wdt_clear;
		logic                     resume;
		logic                     resume_isr;
		logic                     low_power_rc_oscillator_run;
		idc_apb_rsp_t             rsp;
	} idc_top_state_t;

	typedef struct packed {
		logic [`IDC_DIV_W-1:0] cnt;
		logic                  tick;
	} idc_div_state_t;

	typedef struct packed {
		logic en;
	} idc_gate_state_t;

endpackage

// ==== idc_power_ctrl.sv ====
// Idle and doze power controller with an APB register file.
// Assumes pclk is the free running system clock and all inputs are synchronous to it.
//
// Overview of operation
// - In idle the CPU clock alone is gated and execution stops.
// - Entering idle clears the watchdog count automatically.
// - System clock keeps running in idle; peripherals run unless individually gated.
// - Low power oscillator keeps running when watchdog or fail monitor is on.
// - Idle ends on an enabled interrupt, any reset or a watchdog time-out.
// - After wake the CPU clock returns and execution resumes two to four cycles later.
// - Execution resumes after the power save instruction, or in the handler.
// - Interrupt during the power save instruction waits for entry, then wakes.
// - Doze keeps system and peripheral clocks at full speed; only CPU slows.
// - Slowed CPU domain stays aligned with the peripheral clock domain.
// - Slowdown enable bit 11 of the divider control register starts doze.
// - Three ratio bits 14 to 12 choose 1:1 up to 1:128, default 1:1.
// - With return on interrupt set, an interrupt restores full CPU speed.
// - With return on interrupt clear, interrupts leave doze unchanged.
// - A module clock gate bit takes effect one cycle after it changes.
`timescale 1ns/1ns
`include "idc_consts.svh"

module idc_power_ctrl #(
	parameter int NUM_MOD = 8
) (
	input  logic                        pclk,
	input  logic                        presetn,
	input  idc_pkg::idc_apb_req_t       apb_req,
	output idc_pkg::idc_apb_rsp_t       apb_rsp,
	input  logic                        psave_idle,
	input  logic                        irq_pending,
	input  logic                        wdt_timeout,
	output logic                        cpu_clk_en,
	output logic                        wdt_clear,
	output logic                        cpu_resume,
	output logic                        resume_isr,
	output logic                        low_power_rc_oscillator_run,
	output logic [NUM_MOD-1:0]          periph_clk_en
);
	import idc_pkg::*;

	localparam logic [`IDC_MOD_MAX-1:0] GATE_MASK =
		`IDC_MOD_MAX'((17'h1 << NUM_MOD) - 17'h1);

	idc_top_state_t st_ff;
	idc_top_state_t nxt_st;
	logic           setup;
	logic           acc;
	logic           wr;
	logic           wr_div;
	logic           wake_now;
	logic           div_tick;

	generate
		if (NUM_MOD < 1 || NUM_MOD > `IDC_MOD_MAX) begin : g_bad_num
			$error("NUM_MOD must lie between 1 and 16");
		end
	endgenerate

	idc_doze_div u_div (
		.pclk    (pclk),
		.presetn (presetn),
		.enable  (st_ff.slow),
		.ratio   (st_ff.ratio),
		.tick    (div_tick)
	);

	generate
		for (genvar i = 0; i < NUM_MOD; i++) begin : g_gate
			idc_mod_gate u_gate (
				.pclk     (pclk),
				.presetn  (presetn),
				.gate_off (st_ff.gate[i]),
				.clk_en   (periph_clk_en[i])
			);
		end
	endgenerate

	always_comb begin
		nxt_st = st_ff;
		nxt_st.wdt_clear = 1'b0;
		nxt_st.resume = 1'b0;
		setup = apb_req.psel & ~apb_req.penable;
		acc = apb_req.psel & apb_req.penable & st_ff.rsp.pready;
		wr = acc & apb_req.pwrite;
		wr_div = wr & (apb_req.paddr == `IDC_OFS_CLOCK_DIVIDER_CONTROL);
		wake_now = irq_pending | wdt_timeout | st_ff.wake_pend;

		// The answer is prepared in the setup cycle, so every access has one wait-free cycle.
		nxt_st.rsp.pready = setup;
		if (setup) begin
			nxt_st.rsp.pslverr = 1'b0;
			case (apb_req.paddr)
				`IDC_OFS_CLOCK_DIVIDER_CONTROL: begin
					nxt_st.rsp.prdata = '0;
					nxt_st.rsp.prdata[`IDC_BIT_ROI] = st_ff.return_on_interrupt;
					nxt_st.rsp.prdata[`IDC_RATIO_HI:`IDC_RATIO_LO] = st_ff.ratio;
					nxt_st.rsp.prdata[`IDC_BIT_SLOW] = st_ff.slow;
				end
				`IDC_OFS_CFG: begin
					nxt_st.rsp.prdata = '0;
					nxt_st.rsp.prdata[`IDC_BIT_WDTEN] = st_ff.wdt_en;
					nxt_st.rsp.prdata[`IDC_BIT_FMEN] = st_ff.fm_en;
				end
				`IDC_OFS_GATE: begin
					nxt_st.rsp.prdata = {16'h0000, st_ff.gate};
				end
				`IDC_OFS_STAT: begin
					nxt_st.rsp.prdata = {27'h0000000, st_ff.by_wdt, st_ff.by_irq,
						st_ff.pwr == IDC_WAKE, st_ff.slow,
						st_ff.pwr == IDC_IDLE || st_ff.pwr == IDC_ENTER};
				end
				default: begin
					nxt_st.rsp.prdata = '0;
					nxt_st.rsp.pslverr = 1'b1;
				end
			endcase
		end else if (acc) begin
			nxt_st.rsp.pslverr = 1'b0;
		end

		if (wr) begin
			case (apb_req.paddr)
				`IDC_OFS_CLOCK_DIVIDER_CONTROL: begin
					nxt_st.return_on_interrupt = apb_req.pwdata[`IDC_BIT_ROI];
					nxt_st.ratio = apb_req.pwdata[`IDC_RATIO_HI:`IDC_RATIO_LO];
					nxt_st.slow = apb_req.pwdata[`IDC_BIT_SLOW];
				end
				`IDC_OFS_CFG: begin
					nxt_st.wdt_en = apb_req.pwdata[`IDC_BIT_WDTEN];
					nxt_st.fm_en = apb_req.pwdata[`IDC_BIT_FMEN];
				end
				`IDC_OFS_GATE: begin
					nxt_st.gate = apb_req.pwdata[`IDC_MOD_MAX-1:0] & GATE_MASK;
				end
				default: begin
					nxt_st.gate = st_ff.gate;
				end
			endcase
		end

		// Return on interrupt
		// A software write to the divider register in the same cycle takes priority.
		// Doze kept otherwise
		if (st_ff.slow && st_ff.return_on_interrupt && irq_pending && !wr_div) begin
			nxt_st.slow = 1'b0;
		end

		case (st_ff.pwr)
			IDC_RUN: begin
				if (psave_idle) begin
					nxt_st.pwr = IDC_ENTER;
					nxt_st.wdt_clear = 1'b1;
					nxt_st.wake_pend = 1'b0;
				end
			end
			IDC_ENTER: begin
				nxt_st.pwr = IDC_IDLE;
				nxt_st.wake_pend = wdt_timeout;
			end
			IDC_IDLE: begin
				if (wake_now) begin
					nxt_st.pwr = IDC_WAKE;
					nxt_st.wake_cnt = `IDC_WAKE_CYC - 2'h1;
					nxt_st.by_irq = irq_pending;
					nxt_st.by_wdt = wdt_timeout | st_ff.wake_pend;
					nxt_st.wake_pend = 1'b0;
				end
			end
			IDC_WAKE: begin
				if (st_ff.wake_cnt == 2'h0) begin
					nxt_st.pwr = IDC_RUN;
					nxt_st.resume = 1'b1;
					nxt_st.resume_isr = st_ff.by_irq;
				end else begin
					nxt_st.wake_cnt = st_ff.wake_cnt - 2'h1;
				end
			end
			default: begin
				nxt_st.pwr = IDC_RUN;
			end
		endcase

		nxt_st.cpu_clk_en = (nxt_st.pwr == IDC_RUN || nxt_st.pwr == IDC_WAKE)
			& (div_tick | ~nxt_st.slow);
		nxt_st.low_power_rc_oscillator_run = nxt_st.wdt_en | nxt_st.fm_en;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '{
				pwr:        IDC_RUN,
				wake_cnt:   2'h0,
				wake_pend:  1'b0,
				by_irq:     1'b0,
				by_wdt:     1'b0,
				return_on_interrupt:        1'b0,
				ratio:      `IDC_RATIO_RST,
				slow:       1'b0,
				wdt_en:     `IDC_CFG_RST,
				fm_en:      `IDC_CFG_RST,
				gate:       `IDC_GATE_RST,
				cpu_clk_en: 1'b1,
				wdt_clear:  1'b0,
				resume:     1'b0,
				resume_isr: 1'b0,
				low_power_rc_oscillator_run:   1'b0,
				rsp:        '0
			};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign apb_rsp    = st_ff.rsp;
	assign cpu_clk_en = st_ff.cpu_clk_en;
	assign wdt_clear  = st_ff.wdt_clear;
	assign cpu_resume = st_ff.resume;
	assign resume_isr = st_ff.resume_isr;
	assign low_power_rc_oscillator_run   = st_ff.low_power_rc_oscillator_run;

	AST_IDLE_GATED: assert property (@(posedge pclk) disable iff (!presetn)
		(st_ff.pwr == IDC_IDLE || st_ff.pwr == IDC_ENTER) |-> !cpu_clk_en)
		else $error("CPU clock running during idle");

	AST_WDT_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
		(st_ff.pwr == IDC_RUN && psave_idle) |=> wdt_clear ##1 !wdt_clear)
		else $error("watchdog not cleared once on idle entry");

	AST_MOD_IN_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
		(st_ff.pwr == IDC_IDLE && !st_ff.gate[0]) |-> periph_clk_en[0])
		else $error("ungated module stopped during idle");

	AST_LOW_POWER_RC_OSCILLATOR_KEPT: assert property (@(posedge pclk) disable iff (!presetn)
		(st_ff.wdt_en || st_ff.fm_en) |-> low_power_rc_oscillator_run)
		else $error("low power oscillator stopped while needed");

	AST_WAKE_SRC: assert property (@(posedge pclk) disable iff (!presetn)
		(st_ff.pwr == IDC_IDLE && (irq_pending || wdt_timeout)) |=> st_ff.pwr == IDC_WAKE)
		else $error("idle did not end on a wake source");

	AST_RESUME_TIME: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(cpu_clk_en) && st_ff.pwr == IDC_WAKE |-> ##[1:3] cpu_resume)
		else $error("execution did not resume two to four cycles after wake");

	AST_RESUME_ISR: assert property (@(posedge pclk) disable iff (!presetn)
		(st_ff.pwr == IDC_IDLE && irq_pending) |-> ##4 (cpu_resume && resume_isr))
		else $error("interrupt wake did not resume into the handler");

	AST_DEFERRED: assert property (@(posedge pclk) disable iff (!presetn)
		(st_ff.pwr == IDC_ENTER && irq_pending) |=> st_ff.pwr == IDC_IDLE ##1 st_ff.pwr == IDC_WAKE)
		else $error("coincident interrupt not deferred then taken");

	AST_DOZE_RATE: assert property (@(posedge pclk) disable iff (!presetn)
		(st_ff.pwr == IDC_RUN && !psave_idle && !st_ff.slow && $stable(st_ff.slow))
		|=> cpu_clk_en)
		else $error("CPU clock slowed without doze");

	AST_ROI_EXIT: assert property (@(posedge pclk) disable iff (!presetn)
		(st_ff.slow && st_ff.return_on_interrupt && irq_pending && !wr_div) |=> !st_ff.slow)
		else $error("return on interrupt left doze active");

	AST_ROI_OFF: assert property (@(posedge pclk) disable iff (!presetn)
		(st_ff.slow && !st_ff.return_on_interrupt && irq_pending && !wr_div) |=> st_ff.slow)
		else $error("interrupt changed doze without return on interrupt");

	AST_DOZE_ENTER: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_div && apb_req.pwdata[`IDC_BIT_SLOW]) |=> st_ff.slow)
		else $error("slowdown enable write did not start doze");

	AST_DOZE_CLR: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_div && !apb_req.pwdata[`IDC_BIT_SLOW]) |=> !st_ff.slow)
		else $error("slowdown enable clear did not stop doze");

	AST_RATIO_WR: assert property (@(posedge pclk) disable iff (!presetn)
		wr_div |=> st_ff.ratio == $past(apb_req.pwdata[`IDC_RATIO_HI:`IDC_RATIO_LO]))
		else $error("ratio field did not take the written value");

	AST_FULL_SPEED: assert property (@(posedge pclk) disable iff (!presetn)
		(st_ff.pwr == IDC_RUN && !psave_idle && st_ff.slow && st_ff.ratio == 3'h0
		&& $past(st_ff.slow) && $past(st_ff.ratio) == 3'h0) |=> cpu_clk_en)
		else $error("ratio 1:1 skipped a CPU cycle");

	AST_ROI_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(st_ff.slow) |-> ($past(wr_div) || $past(st_ff.return_on_interrupt && irq_pending)))
		else $error("slowdown enable cleared without cause");

	AST_DOZE_PERIPH: assert property (@(posedge pclk) disable iff (!presetn)
		(st_ff.slow && !st_ff.gate[0] && !$past(st_ff.gate[0])) |-> periph_clk_en[0])
		else $error("ungated module slowed during doze");

	AST_MOD_GATED: assert property (@(posedge pclk) disable iff (!presetn)
		(st_ff.gate[0] && $past(st_ff.gate[0])) |-> !periph_clk_en[0])
		else $error("gated module still clocked");

	AST_LOW_POWER_RC_OSCILLATOR_EXACT: assert property (@(posedge pclk) disable iff (!presetn)
		low_power_rc_oscillator_run == (st_ff.wdt_en || st_ff.fm_en))
		else $error("low power oscillator request does not follow its enables");

	AST_CLEAR_ONLY_RUN: assert property (@(posedge pclk) disable iff (!presetn)
		(st_ff.pwr != IDC_RUN) |=> !wdt_clear)
		else $error("watchdog cleared outside idle entry");

	AST_ENTER_ONCE: assert property (@(posedge pclk) disable iff (!presetn)
		(st_ff.pwr == IDC_ENTER) |=> st_ff.pwr == IDC_IDLE)
		else $error("idle entry did not complete");

	AST_IDLE_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		(st_ff.pwr == IDC_IDLE && !irq_pending && !wdt_timeout && !st_ff.wake_pend)
		|=> st_ff.pwr == IDC_IDLE)
		else $error("idle ended without a wake source");

	AST_WDT_DEFER: assert property (@(posedge pclk) disable iff (!presetn)
		(st_ff.pwr == IDC_ENTER && wdt_timeout)
		|=> st_ff.pwr == IDC_IDLE ##1 st_ff.pwr == IDC_WAKE)
		else $error("watchdog time-out during entry was lost");

	AST_WAKE_CLK: assert property (@(posedge pclk) disable iff (!presetn)
		($past(st_ff.pwr) == IDC_IDLE && st_ff.pwr == IDC_WAKE && !st_ff.slow)
		|-> cpu_clk_en)
		else $error("CPU clock not reapplied on wake");

	AST_RESUME_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
		cpu_resume |=> !cpu_resume)
		else $error("resume pulse longer than one cycle");

	AST_RESUME_NEXT: assert property (@(posedge pclk) disable iff (!presetn)
		($past(st_ff.pwr) == IDC_IDLE && st_ff.pwr == IDC_WAKE && !$past(irq_pending))
		|-> ##3 (cpu_resume && !resume_isr))
		else $error("watchdog wake did not resume at the next instruction");

endmodule

// ==== tb_top.sv ====
// Self-checking bench for the idle and doze power controller.
// Assumes idc_consts.svh and idc_pkg are compiled first; NUM_MOD is 8.
`timescale 1ns/1ns
`include "idc_consts.svh"

module tb_top;
	import idc_pkg::*;
	logic         pclk = 1'h0;
	logic         presetn = 1'h0;
	idc_apb_req_t req = '0;
	idc_apb_rsp_t rsp;
	logic         req_idle = 1'h0;
	logic         req_irq = 1'h0;
	logic         req_wdt = 1'h0;
	logic         psave_idle;
	logic         irq_pending;
	logic         wdt_timeout;
	logic         cpu_clk_en;
	logic         wdt_clear;
	logic         cpu_resume;
	logic         resume_isr;
	logic         low_power_rc_oscillator_run;
	logic [7:0]   periph_clk_en;
	logic [15:0]  lfsr = 16'h0025;
	logic [7:0]   gate = 8'h00;
	logic [32:0]  exp_q[$];
	int           n_mismatch = 0;
	int           compares = 0;
	int           p;

	always #5 pclk = ~pclk;

	idc_power_ctrl #(.NUM_MOD(8)) u_dut (
		.pclk         (pclk),
		.presetn      (presetn),
		.apb_req      (req),
		.apb_rsp      (rsp),
		.psave_idle   (psave_idle),
		.irq_pending  (irq_pending),
		.wdt_timeout  (wdt_timeout),
		.cpu_clk_en   (cpu_clk_en),
		.wdt_clear    (wdt_clear),
		.cpu_resume   (cpu_resume),
		.resume_isr   (resume_isr),
		.low_power_rc_oscillator_run     (low_power_rc_oscillator_run),
		.periph_clk_en(periph_clk_en)
	);

	idc_cpu_model u_cpu (
		.pclk       (pclk),
		.presetn    (presetn),
		.req_idle   (req_idle),
		.req_irq    (req_irq),
		.req_wdt    (req_wdt),
		.cpu_clk_en (cpu_clk_en),
		.psave_idle (psave_idle),
		.irq_pending(irq_pending),
		.wdt_timeout(wdt_timeout)
	);

	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	task automatic check(input string nm, input logic [32:0] s, input logic [32:0] e);
		compares++;
		if (s !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, s);
			n_mismatch++;
		end
	endtask

	task automatic finish_test();
		if (n_mismatch == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Reads note {pslverr, prdata} here; the monitor below compares them.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			input logic [32:0] e);
		@(posedge pclk);
		if (!wr) begin
			exp_q.push_back(e);
		end
		req <= '{1'h1, 1'h0, wr, a, d};
		@(posedge pclk);
		req.penable <= 1'h1;
		do @(posedge pclk); while (rsp.pready !== 1'h1);
		req <= '0;
	endtask

	always @(posedge pclk) begin
		if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'h1) begin
			check("read", {rsp.pslverr, rsp.prdata}, exp_q.pop_front());
		end
	end

	task automatic period(output int n);
		n = 0;
		do @(negedge pclk); while (cpu_clk_en !== 1'h1);
		do begin
			@(negedge pclk);
			n++;
		end while (cpu_clk_en !== 1'h1);
	endtask

	task automatic idle_run(input logic irq);
		int n;
		@(posedge pclk);
		req_idle <= 1'h1;
		req_irq <= irq;
		@(posedge pclk);
		req_idle <= 1'h0;
		repeat (2) @(negedge pclk);
		check("cpu_clk_en", cpu_clk_en, 1'h0);
		check("wdt_clear", wdt_clear, 1'h1);
		check("periph idle", periph_clk_en, 8'(~gate));
		check("low_power_rc_oscillator idle", low_power_rc_oscillator_run, 1'h1);
		if (!irq) begin
			repeat (5) @(negedge pclk);
			check("still idle", cpu_clk_en, 1'h0);
			@(posedge pclk);
			req_wdt <= 1'h1;
			@(posedge pclk);
			req_wdt <= 1'h0;
		end
		do @(negedge pclk); while (cpu_clk_en !== 1'h1);
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (cpu_resume !== 1'h1);
		check("wake delay", 33'(n), 33'(`IDC_WAKE_CYC));
		check("resume_isr", resume_isr, irq);
		@(posedge pclk);
		req_irq <= 1'h0;
		apb(1'h0, `IDC_OFS_STAT, 32'h0, {28'h0, ~irq, irq, 3'h0});
	endtask

	task automatic doze_irq(input logic [31:0] w, input logic [31:0] e, input int per);
		apb(1'h1, `IDC_OFS_CLOCK_DIVIDER_CONTROL, w, 33'h0);
		@(posedge pclk);
		req_irq <= 1'h1;
		repeat (4) @(posedge pclk);
		apb(1'h0, `IDC_OFS_CLOCK_DIVIDER_CONTROL, 32'h0, {1'h0, e});
		period(p);
		check("doze irq period", 33'(p), 33'(per));
		@(posedge pclk);
		req_irq <= 1'h0;
	endtask

	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'h1;
		@(negedge pclk);
		check("cpu_clk_en rst", cpu_clk_en, 1'h1);
		check("periph rst", periph_clk_en, 8'hFF);
		for (int i = 0; i < 4; i++) begin
			apb(1'h0, 8'(4 * i), 32'h0, 33'h0);
		end
		apb(1'h0, 8'h10, 32'h0, 33'h1_0000_0000);
		apb(1'h1, `IDC_OFS_STAT, 32'hFFFF_FFFF, 33'h0);
		apb(1'h0, `IDC_OFS_STAT, 32'h0, 33'h0);
		for (int v = 0; v < 4; v++) begin
			apb(1'h1, `IDC_OFS_CFG, 32'(v), 33'h0);
			apb(1'h0, `IDC_OFS_CFG, 32'h0, 33'(v));
			check("low_power_rc_oscillator_run", low_power_rc_oscillator_run, 1'(v != 0));
		end
		for (int k = 0; k < 4; k++) begin
			lfsr = lfsr_next(lfsr);
			apb(1'h1, `IDC_OFS_GATE, {16'h0, lfsr}, 33'h0);
			@(negedge pclk);
			check("gate delay", periph_clk_en, 8'(~gate));
			gate = lfsr[7:0];
			@(negedge pclk);
			check("gate", periph_clk_en, 8'(~gate));
			apb(1'h0, `IDC_OFS_GATE, 32'h0, {25'h0, gate});
		end
		idle_run(1'h1);
		idle_run(1'h0);
		for (int n = 0; n < 8; n++) begin
			apb(1'h1, `IDC_OFS_CLOCK_DIVIDER_CONTROL, 32'h800 | 32'(n << 12), 33'h0);
			apb(1'h0, `IDC_OFS_CLOCK_DIVIDER_CONTROL, 32'h0, 33'(32'h800 | 32'(n << 12)));
			period(p);
			period(p);
			check("doze period", 33'(p), 33'(1 << n));
			check("doze periph", periph_clk_en, 8'(~gate));
		end
		doze_irq(32'h0000_A800, 32'h0000_A000, 1);
		doze_irq(32'h0000_2800, 32'h0000_2800, 4);
		finish_test();
	end

	initial begin
		repeat (30000) @(posedge pclk);
		n_mismatch++;
		finish_test();
	end
endmodule
